// ### core/tlir_top.sv
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

//
// How it works
// - Taking an interrupt clears the global enable of the level taken.
// - Compatible mode uses one enable; priority mode splits high and low.
// - High preempts a running low handler; low waits while high runs.
// - On entry the return address is pushed and the vector loaded.
// - The return operation leaves the handler and re-sets its enable.
// - Pin and port-change events reach the vector in three to four instruction cycles.
// - Flags set on their event regardless of any enable.
// - Main bit 7 is global enable, or high enable in priority mode.
// - Main bit 6 is peripheral enable, or low enable in priority mode.
// - Main bits 5 and 4 gate timer0 overflow and external 0.
// - Main bit 3 enables port change; pins also need their own enable.
// - Flag bits 2 and 1 set on their event and stay until cleared.
// - Port-change flag keeps setting on mismatch; port reads end it.
// - Second bit 7 disables pull-ups; else per-pin bit on inputs.
// - Second bits 6..4 pick rising or falling edge for externals.
// - Second bits 2 and 0 give timer0 and port-change priority.
// - Reset clears main register and sets implemented second bits.
// - Flag, enable and global enable together take the interrupt.
// - In compatible mode every interrupt vectors to the high address.
// - Priority mode is a separate mode bit, off after reset.
module tlir_top #(
	parameter int PA_W = 3,
	parameter int PB_W = 4
) (
	input  wire logic            core_clk,
	input  wire logic            reset_n,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            timer0_overflow,
	input  wire logic            ext_irq0_pin,
	input  wire logic [PA_W-1:0] first_io_port_pins,
	input  wire logic [PB_W-1:0] second_io_port_pins,
	input  wire logic [PA_W-1:0] first_io_port_pin_change_enables,
	input  wire logic [PB_W-1:0] second_io_port_pin_change_enables,
	input  wire logic            first_io_port_read,
	input  wire logic            second_io_port_read,
	input  wire logic [PA_W-1:0] first_io_port_pullup_bits,
	input  wire logic [PB_W-1:0] second_io_port_pullup_bits,
	input  wire logic [PA_W-1:0] first_io_port_is_input,
	input  wire logic [PB_W-1:0] second_io_port_is_input,
	input  wire logic            periph_high_req,
	input  wire logic            periph_low_req,
	input  wire logic            return_from_handler_op,
	input  wire logic [15:0]     return_pc,
	output logic                 enter_handler,
	output logic      [15:0]     vector_addr,
	output logic      [15:0]     push_addr,
	output logic      [PA_W-1:0] first_io_port_pullup_en,
	output logic      [PB_W-1:0] second_io_port_pullup_en,
	output logic                 ext_irq1_edge_select,
	output logic                 ext_irq2_edge_select
);

	localparam int LAT_W = $clog2(tlir_pkg::LAT_CLKS);
	localparam int SW    = 1 + PA_W + PB_W;
	localparam logic [LAT_W-1:0] LAT_LAST =
		LAT_W'(tlir_pkg::LAT_CLKS - 1);

	typedef struct packed {
		logic [7:0]            main;
		logic [7:0]            second;
		logic                  prio_mode;
		tlir_pkg::tlir_level_t lvl;
		logic [LAT_W-1:0]      lat;
		logic [PA_W-1:0]       la;
		logic [PB_W-1:0]       lb;
		logic [31:0]           rdata;
		logic                  rdy;
		logic                  err;
		logic                  enter;
		logic [15:0]           vec;
		logic [15:0]           push;
		logic [PA_W-1:0]       pua;
		logic [PB_W-1:0]       pub;
	} tlir_state_t;

	tlir_state_t st;
	tlir_state_t next_st;

	logic [SW-1:0]   pin_lvl;
	logic [SW-1:0]   pin_rise;
	logic [SW-1:0]   pin_fall;
	logic [PA_W-1:0] pa_lvl;
	logic [PB_W-1:0] pb_lvl;
	logic            int0_event;
	logic            mismatch;
	logic            pend_t0;
	logic            pend_i0;
	logic            pend_pc;
	logic            hi_req;
	logic            lo_req;
	logic            cand;
	logic            take;
	logic            take_hi;
	logic            wr;
	logic            wr_main;

	// --------------------------------------------------------------
	// Pin synchronisers.
	// --------------------------------------------------------------
	tlir_sync #(
		.W(SW)
	) u_sync (
		.core_clk(core_clk),
		.reset_n (reset_n),
		.pins    ({ext_irq0_pin, first_io_port_pins,
		            second_io_port_pins}),
		.level   (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// --------------------------------------------------------------
	// Event detection.
	// --------------------------------------------------------------

	// The port latches hold the last read value; any enabled pin that
	// differs is a standing mismatch that keeps re-setting the flag.
	assign pa_lvl     = pin_lvl[PB_W +: PA_W];
	assign pb_lvl     = pin_lvl[PB_W-1:0];
	assign mismatch   = |((pa_lvl ^ st.la) & first_io_port_pin_change_enables) |
	                    |((pb_lvl ^ st.lb) & second_io_port_pin_change_enables);
	assign int0_event = st.second[tlir_pkg::B_EDG0] ? pin_rise[SW-1]
	                                                : pin_fall[SW-1];

	// --------------------------------------------------------------
	// Request gating.
	// --------------------------------------------------------------

	// Per-source pending terms from flag and enable.
	assign pend_t0 = st.main[tlir_pkg::B_T0IF] & st.main[tlir_pkg::B_T0IE];
	assign pend_i0 = st.main[tlir_pkg::B_I0IF] & st.main[tlir_pkg::B_I0IE];
	assign pend_pc = st.main[tlir_pkg::B_PCIF] & st.main[tlir_pkg::B_PCIE];

	// In compatible mode everything is one level behind bit 7, with the
	// peripheral group also behind bit 6. External 0 is always high.
	// Low requests are also held off while a high handler runs, even if
	// software re-opens the high enable inside that handler.
	always_comb begin
		if (!st.prio_mode) begin
			hi_req = st.main[tlir_pkg::B_GLB_EN] &
			         (pend_t0 | pend_i0 | pend_pc |
			          (st.main[tlir_pkg::B_GRP_EN] &
			           (periph_high_req | periph_low_req)));
			lo_req = 1'b0;
		end else begin
			hi_req = st.main[tlir_pkg::B_GLB_EN] &
			         ((pend_t0 & st.second[tlir_pkg::B_T0IP]) | pend_i0 |
			          (pend_pc & st.second[tlir_pkg::B_PCIP]) |
			          periph_high_req);
			lo_req = st.main[tlir_pkg::B_GLB_EN] &
			         st.main[tlir_pkg::B_GRP_EN] &
			         (st.lvl != tlir_pkg::LVL_HIGH) &
			         (st.lvl != tlir_pkg::LVL_BOTH) &
			         ((pend_t0 & ~st.second[tlir_pkg::B_T0IP]) |
			          (pend_pc & ~st.second[tlir_pkg::B_PCIP]) |
			          periph_low_req);
		end
	end

	// A request must stand for the full latency before it is taken.
	assign cand    = hi_req | lo_req;
	assign take    = cand & (st.lat == LAT_LAST);
	assign take_hi = take & hi_req;

	// --------------------------------------------------------------
	// Bus strobes.
	// --------------------------------------------------------------
	assign wr      = psel & penable & st.rdy & pwrite;
	assign wr_main = wr & (paddr == tlir_pkg::OFF_MAIN);

	// --------------------------------------------------------------
	// Next-state logic.
	// --------------------------------------------------------------
	always_comb begin
		next_st       = st;
		next_st.rdy   = psel & ~penable;
		next_st.err   = 1'b0;
		next_st.rdata = 32'h0000_0000;
		next_st.enter = 1'b0;

		// Read data is prepared in the setup cycle; unmapped reads
		// answer zero with an error.
		if (psel & ~penable) begin
			case (paddr)
				tlir_pkg::OFF_MAIN: begin
					next_st.rdata = {24'h00_0000, st.main};
				end
				tlir_pkg::OFF_SECOND: begin
					next_st.rdata = {24'h00_0000, st.second};
				end
				tlir_pkg::OFF_MODE: begin
					next_st.rdata = {31'h0000_0000, st.prio_mode};
				end
				tlir_pkg::OFF_STATUS: begin
					next_st.rdata = {28'h000_0000, st.lvl, hi_req, lo_req};
				end
				default: begin
					next_st.err = 1'b1;
				end
			endcase
		end

		// Register writes land first so that events below win.
		if (wr) begin
			case (paddr)
				tlir_pkg::OFF_MAIN: begin
					next_st.main = pwdata[7:0];
				end
				tlir_pkg::OFF_SECOND: begin
					next_st.second = pwdata[7:0] & tlir_pkg::MASK_SECOND;
				end
				tlir_pkg::OFF_MODE: begin
					next_st.prio_mode = pwdata[tlir_pkg::B_PMODE];
				end
				default: begin
				end
			endcase
		end

		// Flags set whatever the enables; a set beats a same-cycle clear.
		if (timer0_overflow) begin
			next_st.main[tlir_pkg::B_T0IF] = 1'b1;
		end
		if (int0_event) begin
			next_st.main[tlir_pkg::B_I0IF] = 1'b1;
		end
		if (mismatch) begin
			next_st.main[tlir_pkg::B_PCIF] = 1'b1;
		end

		// A port read re-arms its latch and so ends the mismatch.
		if (first_io_port_read) begin
			next_st.la = pa_lvl;
		end
		if (second_io_port_read) begin
			next_st.lb = pb_lvl;
		end

		// Latency counter restarts whenever the request drops.
		if (!cand || take) begin
			next_st.lat = '0;
		end else begin
			next_st.lat = st.lat + 1'b1;
		end

		// Return re-opens the level that is ending.
		if (return_from_handler_op) begin
			case (st.lvl)
				tlir_pkg::LVL_BOTH: begin
					next_st.lvl                      = tlir_pkg::LVL_LOW;
					next_st.main[tlir_pkg::B_GLB_EN] = 1'b1;
				end
				tlir_pkg::LVL_HIGH: begin
					next_st.lvl                      = tlir_pkg::LVL_IDLE;
					next_st.main[tlir_pkg::B_GLB_EN] = 1'b1;
				end
				tlir_pkg::LVL_LOW: begin
					next_st.lvl                      = tlir_pkg::LVL_IDLE;
					next_st.main[tlir_pkg::B_GRP_EN] = 1'b1;
				end
				default: begin
					next_st.main[tlir_pkg::B_GLB_EN] = 1'b1;
				end
			endcase
		end

		// Entry: push, vector and close the enable of the level taken.
		if (take) begin
			next_st.enter = 1'b1;
			next_st.push  = return_pc;
			if (take_hi) begin
				next_st.vec                   = tlir_pkg::VEC_HIGH;
				next_st.main[tlir_pkg::B_GLB_EN] = 1'b0;
				next_st.lvl = (st.lvl == tlir_pkg::LVL_LOW) ?
				              tlir_pkg::LVL_BOTH : tlir_pkg::LVL_HIGH;
			end else begin
				next_st.vec                    = tlir_pkg::VEC_LOW;
				next_st.main[tlir_pkg::B_GRP_EN] = 1'b0;
				next_st.lvl                    = tlir_pkg::LVL_LOW;
			end
		end

		// Pull-ups follow the register that will be current next cycle.
		next_st.pua = next_st.second[tlir_pkg::B_PUDIS] ? '0 :
		              (first_io_port_pullup_bits & first_io_port_is_input);
		next_st.pub = next_st.second[tlir_pkg::B_PUDIS] ? '0 :
		              (second_io_port_pullup_bits & second_io_port_is_input);
	end

	// --------------------------------------------------------------
	// State register.
	// --------------------------------------------------------------

	// The port-change flag comes up cleared rather than unknown so that
	// simulation starts clean.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st        <= '0;
			st.main   <= tlir_pkg::RST_MAIN;
			st.second <= tlir_pkg::RST_SECOND;
			st.prio_mode <= tlir_pkg::RST_PMODE;
			st.lvl    <= tlir_pkg::LVL_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Every output is a flop of the state.
	assign prdata               = st.rdata;
	assign pready               = st.rdy;
	assign pslverr              = st.err;
	assign enter_handler        = st.enter;
	assign vector_addr          = st.vec;
	assign push_addr            = st.push;
	assign first_io_port_pullup_en      = st.pua;
	assign second_io_port_pullup_en      = st.pub;
	assign ext_irq1_edge_select = st.second[tlir_pkg::B_EDG1];
	assign ext_irq2_edge_select = st.second[tlir_pkg::B_EDG2];

	// --------------------------------------------------------------
	// Assertions.
	// --------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_entry_closes_enable: assert property (
		st.enter && !$past(st.prio_mode) |-> !st.main[tlir_pkg::B_GLB_EN])
		else $error("global enable still set after entry");
	a_low_held_off: assert property (
		st.lvl == tlir_pkg::LVL_HIGH && take |-> take_hi)
		else $error("low request taken inside high handler");
	a_compat_vector: assert property (
		st.enter && !$past(st.prio_mode) |-> st.vec == tlir_pkg::VEC_HIGH)
		else $error("compatible mode used the low vector");
	a_return_reenables: assert property (
		return_from_handler_op && !st.prio_mode && !take
		|=> st.main[tlir_pkg::B_GLB_EN])
		else $error("return did not set the global enable");
	a_latency_count: assert property (
		st.enter |-> $past(st.lat) == LAT_LAST && $past(cand))
		else $error("entry without full latency");
	a_timer_flag_sets: assert property (
		timer0_overflow |=> st.main[tlir_pkg::B_T0IF])
		else $error("timer0 flag missed its event");
	a_flag_sticky: assert property (
		st.main[tlir_pkg::B_T0IF] && !wr_main |=> st.main[tlir_pkg::B_T0IF])
		else $error("timer0 flag dropped without a write");
	a_mismatch_sets: assert property (
		mismatch |=> st.main[tlir_pkg::B_PCIF])
		else $error("mismatch did not set port-change flag");
	a_pullup_off: assert property (
		st.second[tlir_pkg::B_PUDIS] |-> st.pua == '0 && st.pub == '0)
		else $error("pull-up active while globally disabled");

	c_enter_high: cover property (st.enter && st.vec == tlir_pkg::VEC_HIGH);
	c_enter_low: cover property (st.enter && st.vec == tlir_pkg::VEC_LOW);
	c_preempt: cover property (st.lvl == tlir_pkg::LVL_BOTH);
	c_return: cover property (return_from_handler_op &&
	                          st.lvl != tlir_pkg::LVL_IDLE);

endmodule

`default_nettype wire

// ### core/tlir_pkg.sv
`default_nettype none

package tlir_pkg;

	// --------------------------------------------------------------
	// Register byte offsets on the APB window.
	// --------------------------------------------------------------
	localparam logic [7:0] OFF_MAIN   = 8'h00;
	localparam logic [7:0] OFF_SECOND = 8'h04;
	localparam logic [7:0] OFF_MODE   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;

	// --------------------------------------------------------------
	// Field positions of interrupt_control_main.
	// --------------------------------------------------------------
	localparam int B_GLB_EN = 7;
	localparam int B_GRP_EN = 6;
	localparam int B_T0IE = 5;
	localparam int B_I0IE = 4;
	localparam int B_PCIE = 3;
	localparam int B_T0IF = 2;
	localparam int B_I0IF = 1;
	localparam int B_PCIF = 0;

	// --------------------------------------------------------------
	// Field positions of interrupt_control_second and the mode bit.
	// --------------------------------------------------------------
	localparam int B_PUDIS = 7;
	localparam int B_EDG0  = 6;
	localparam int B_EDG1  = 5;
	localparam int B_EDG2  = 4;
	localparam int B_T0IP  = 2;
	localparam int B_PCIP  = 0;
	localparam int B_PMODE = 0;

	// --------------------------------------------------------------
	// Reset values and implemented-bit masks.
	// --------------------------------------------------------------
	localparam logic [7:0] RST_MAIN    = 8'h00;
	localparam logic [7:0] RST_SECOND  = 8'hf5;
	localparam logic [7:0] MASK_SECOND = 8'hf5;
	localparam logic       RST_PMODE   = 1'h0;

	// --------------------------------------------------------------
	// Vectors and response latency.
	// --------------------------------------------------------------
	localparam logic [15:0] VEC_HIGH       = 16'h0008;
	localparam logic [15:0] VEC_LOW        = 16'h0018;
	localparam int          CLKS_PER_INSTR = 4;
	localparam int          LAT_INSTR      = 3;
	localparam int          LAT_CLKS       = LAT_INSTR * CLKS_PER_INSTR;

	// Handler nesting, Gray coded along idle, low, both, high.
	typedef enum logic [1:0] {
		LVL_IDLE = 2'b00,
		LVL_LOW  = 2'b01,
		LVL_BOTH = 2'b11,
		LVL_HIGH = 2'b10
	} tlir_level_t;

endpackage

`default_nettype wire

// ### core/tlir_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser per pin plus a third stage for edge detection.
module tlir_sync #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pins,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} tlir_sync_state_t;

	tlir_sync_state_t st;
	tlir_sync_state_t next_st;

	// --------------------------------------------------------------
	// Shift chain; only s2 and s3 feed any logic.
	// --------------------------------------------------------------
	always_comb begin
		next_st    = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Edges come from the settled stages only.
	assign level = st.s2;
	assign rise  = st.s2 & ~st.s3;
	assign fall  = ~st.s2 & st.s3;

endmodule

`default_nettype wire

// ### test/tlir_core_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Processor core model: return addresses and the return operation.
// ----------------------------------------------------------------
module tlir_core_model (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        enter_handler,
	input  wire logic        ret_req,
	output logic      [15:0] return_pc,
	output logic             return_from_handler_op,
	output logic      [1:0]  depth
);
	// Each entry moves the return address on so that every push differs.
	// A return is only issued while a handler is open, as a core would.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			return_pc <= 16'h0100;
			return_from_handler_op <= 1'b0;
			depth <= 2'h0;
		end else begin
			if (enter_handler)
				return_pc <= return_pc + 16'h0010;
			return_from_handler_op <= ret_req && (depth != 2'h0);
			depth <= depth + {1'b0, enter_handler}
				- {1'b0, ret_req && (depth != 2'h0)};
		end
	end
endmodule

`default_nettype wire

// ### test/tlir_top_test.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; \
	if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tlir_top_test;
	logic        core_clk, reset_n, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er, t0, ei0, ra_rd, rb_rd, ret_req;
	logic        enter_handler, ret_op, e1, e2;
	logic [2:0]  ra_pins, ra_ioc, ra_pu, ra_in, ra_pen;
	logic [3:0]  rb_pins, rb_ioc, rb_pu, rb_in, rb_pen;
	logic [15:0] vec, push, rpc;
	logic [1:0]  depth;
	int          bad_count, checks_done, cyc;

	tlir_top DUT (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer0_overflow(t0), .ext_irq0_pin(ei0),
		.first_io_port_pins(ra_pins), .second_io_port_pins(rb_pins),
		.first_io_port_pin_change_enables(ra_ioc),
		.second_io_port_pin_change_enables(rb_ioc),
		.first_io_port_read(ra_rd), .second_io_port_read(rb_rd),
		.first_io_port_pullup_bits(ra_pu), .second_io_port_pullup_bits(rb_pu),
		.first_io_port_is_input(ra_in), .second_io_port_is_input(rb_in),
		.periph_high_req(1'b0), .periph_low_req(1'b0),
		.return_from_handler_op(ret_op), .return_pc(rpc),
		.enter_handler(enter_handler), .vector_addr(vec),
		.push_addr(push), .first_io_port_pullup_en(ra_pen),
		.second_io_port_pullup_en(rb_pen), .ext_irq1_edge_select(e1),
		.ext_irq2_edge_select(e2));

	tlir_core_model CORE (.core_clk(core_clk), .reset_n(reset_n),
		.enter_handler(enter_handler), .ret_req(ret_req),
		.return_pc(rpc), .return_from_handler_op(ret_op),
		.depth(depth));

	// ------------------------------------------------------------
	// Clock and closing report.
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus and event helpers.
	// ------------------------------------------------------------
	// Holds the request until pready is seen high; never a fixed wait.
	task automatic apb(input logic [7:0] a, input logic w,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		apb(a, 1'b0, 32'h0);
		`CHK("read data", {24'h0, e}, rd)
	endtask

	task automatic pulse_t0();
		@(posedge core_clk);
		t0 <= 1'b1;
		@(posedge core_clk);
		t0 <= 1'b0;
	endtask

	task automatic do_ret();
		@(posedge core_clk);
		ret_req <= 1'b1;
		@(posedge core_clk);
		ret_req <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	// Counts cycles to entry; the vector is sampled at the entry edge.
	task automatic wait_entry(input logic [15:0] ev);
		cyc = 0;
		while (enter_handler !== 1'b1 && cyc < 200) begin
			@(posedge core_clk);
			cyc++;
		end
		if (cyc >= 200) begin
			bad_count++;
			stop_test();
		end
		`CHK("vector", ev, vec)
		`CHK("pushed address", rpc, push)
	endtask

	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	task automatic t_reset_map();
		rd_chk(tlir_pkg::OFF_MAIN, tlir_pkg::RST_MAIN);
		rd_chk(tlir_pkg::OFF_SECOND, 8'hf5);
		rd_chk(tlir_pkg::OFF_MODE, 8'h00);
		apb(8'h10, 1'b0, 32'h0);
		`CHK("unmapped error", 1'b1, er)
		apb(tlir_pkg::OFF_SECOND, 1'b1, 32'h0000_000a);
		rd_chk(tlir_pkg::OFF_SECOND, 8'h00);
		`CHK("edge1", 1'b0, e1)
		apb(tlir_pkg::OFF_SECOND, 1'b1, 32'h0000_00ff);
		rd_chk(tlir_pkg::OFF_SECOND, 8'hf5);
		`CHK("edge2", 1'b1, e2)
	endtask

	task automatic t_pullups();
		ra_pu <= 3'b011;
		ra_in <= 3'b110;
		rb_pu <= 4'hf;
		rb_in <= 4'h5;
		repeat (3) @(posedge core_clk);
		`CHK("pull-ups off", 3'b000, ra_pen)
		apb(tlir_pkg::OFF_SECOND, 1'b1, 32'h0000_0075);
		repeat (3) @(posedge core_clk);
		`CHK("first_io_port pull-ups", 3'b010, ra_pen)
		`CHK("second_io_port pull-ups", 4'h5, rb_pen)
	endtask

	task automatic t_compat();
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_0020);
		pulse_t0();
		rd_chk(tlir_pkg::OFF_MAIN, 8'h24);
		repeat (30) @(posedge core_clk);
		`CHK("no entry with global enable off", 1'b0, enter_handler)
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_00a4);
		wait_entry(tlir_pkg::VEC_HIGH);
		rd_chk(tlir_pkg::OFF_MAIN, 8'h24);
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_0020);
		do_ret();
		rd_chk(tlir_pkg::OFF_MAIN, 8'ha0);
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_0000);
	endtask

	task automatic t_priority();
		apb(tlir_pkg::OFF_MODE, 1'b1, 32'h0000_0001);
		apb(tlir_pkg::OFF_SECOND, 1'b1, 32'h0000_0071);
		pulse_t0();
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_00f4);
		wait_entry(tlir_pkg::VEC_LOW);
		rd_chk(tlir_pkg::OFF_MAIN, 8'hb4);
		@(posedge core_clk);
		ei0 <= 1'b1;
		wait_entry(tlir_pkg::VEC_HIGH);
		`CHK("pin latency", 1'b1,
			cyc >= tlir_pkg::LAT_CLKS && cyc <= tlir_pkg::LAT_CLKS + 6)
		rd_chk(tlir_pkg::OFF_MAIN, 8'h36);
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_0030);
		do_ret();
		rd_chk(tlir_pkg::OFF_MAIN, 8'hb0);
		do_ret();
		rd_chk(tlir_pkg::OFF_MAIN, 8'hf0);
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_0000);
	endtask

	task automatic t_port_change();
		rb_pins <= 4'h1;
		repeat (8) @(posedge core_clk);
		rd_chk(tlir_pkg::OFF_MAIN, 8'h00);
		ra_ioc <= 3'b001;
		ra_pins <= 3'b001;
		repeat (8) @(posedge core_clk);
		rd_chk(tlir_pkg::OFF_MAIN, 8'h01);
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_0000);
		rd_chk(tlir_pkg::OFF_MAIN, 8'h01);
		@(posedge core_clk);
		ra_rd <= 1'b1;
		rb_rd <= 1'b1;
		@(posedge core_clk);
		ra_rd <= 1'b0;
		rb_rd <= 1'b0;
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_0000);
		rd_chk(tlir_pkg::OFF_MAIN, 8'h00);
		apb(tlir_pkg::OFF_MAIN, 1'b1, 32'h0000_0002);
		rd_chk(tlir_pkg::OFF_MAIN, 8'h02);
	endtask

	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		{reset_n, psel, penable, pwrite, t0, ei0, ra_rd, rb_rd} = '0;
		{ret_req, paddr, pwdata, ra_pins, rb_pins, ra_ioc, rb_ioc} = '0;
		{ra_pu, rb_pu, ra_in, rb_in, bad_count, checks_done} = '0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset_map();
		t_pullups();
		t_compat();
		t_priority();
		t_port_change();
		stop_test();
	end
endmodule

`default_nettype wire
